// file: rtl/smcs_pkg.sv
// Package of constants, carriers and the check-sum step for the serial motor command slave.
`default_nettype none

package smcs_pkg;

	// ==========================================================================
	// Clock and timing
	// ==========================================================================
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned CLK_PERIOD_NS = 8;
	// Driver silent interval at the top bit rate, in nanoseconds (2.5 ms).
	localparam int unsigned SILENT_NS = 2_500_000;
	// A longest time rounds down to whole cycles.
	localparam int unsigned SILENT_CYC = SILENT_NS / CLK_PERIOD_NS;

	// ==========================================================================
	// Line settings
	// ==========================================================================
	localparam int unsigned RATE_9600 = 9600;
	localparam int unsigned RATE_19200 = 19200;
	localparam int unsigned RATE_38400 = 38400;
	localparam int unsigned RATE_57600 = 57600;
	localparam int unsigned RATE_115200 = 115200;
	localparam logic [15:0] DIV_9600 = 16'(CLK_HZ / RATE_9600);
	localparam logic [15:0] DIV_19200 = 16'(CLK_HZ / RATE_19200);
	localparam logic [15:0] DIV_38400 = 16'(CLK_HZ / RATE_38400);
	localparam logic [15:0] DIV_57600 = 16'(CLK_HZ / RATE_57600);
	localparam logic [15:0] DIV_115200 = 16'(CLK_HZ / RATE_115200);
	localparam logic [3:0] BAUD_SEL_9600 = 4'h0;
	localparam logic [3:0] BAUD_SEL_19200 = 4'h1;
	localparam logic [3:0] BAUD_SEL_38400 = 4'h2;
	localparam logic [3:0] BAUD_SEL_57600 = 4'h3;
	localparam logic [3:0] BAUD_SEL_115200 = 4'h4;
	localparam logic [1:0] PARITY_NONE = 2'h0;
	localparam logic [1:0] PARITY_EVEN = 2'h1;
	localparam logic [1:0] PARITY_ODD = 2'h2;

	// ==========================================================================
	// Frame layout
	// ==========================================================================
	localparam logic [3:0] FRAME_LEN = 4'h8;
	localparam logic [3:0] FRAME_OVER = 4'h9;
	localparam int unsigned POS_SLAVE = 0;
	localparam int unsigned POS_FUNC = 1;
	localparam int unsigned POS_REG_HI = 2;
	localparam int unsigned POS_REG_LO = 3;
	localparam int unsigned POS_VAL_HI = 4;
	localparam int unsigned POS_VAL_LO = 5;
	localparam logic [7:0] FUNC_WRITE_ONE = 8'h06;
	localparam logic [7:0] BCAST_ADDR = 8'h00;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'ha001;
	localparam logic [15:0] CRC_RESIDUE = 16'h0000;

	// ==========================================================================
	// Register map
	// ==========================================================================
	localparam logic [15:0] REG_CMD = 16'h007d;
	localparam logic [15:0] REG_POS = 16'h0401;
	localparam logic [15:0] REG_SPEED = 16'h0481;
	localparam logic [15:0] REG_MODE = 16'h0501;
	localparam logic [15:0] REG_ACCEL = 16'h0601;
	localparam logic [15:0] REG_DECEL = 16'h0681;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [15:0] MODE_INCREMENTAL = 16'h0000;
	localparam int unsigned CMD_START_BIT = 3;
	localparam int unsigned CMD_SEL_MSB = 2;
	localparam logic [15:0] CMD_START = 16'h0008;

	// ==========================================================================
	// Carriers
	// ==========================================================================
	typedef struct packed {
		logic [15:0] drive_input_command;
		logic [15:0] entry0_target_position;
		logic [15:0] entry0_run_speed;
		logic [15:0] entry0_move_mode;
		logic [15:0] entry0_accel_rate;
		logic [15:0] entry0_decel_rate;
	} smcs_regs_type;

	typedef struct packed {
		logic rx;
		logic stop2;
		logic [1:0] parity;
		logic [3:0] baud;
		logic [7:0] addr;
	} smcs_pins_type;

	function automatic logic [15:0] smcs_crc_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++)
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		return r;
	endfunction : smcs_crc_step

endpackage : smcs_pkg

`default_nettype wire

// file: rtl/smcs_uart_rx.sv
// Asynchronous character receiver with selectable parity and stop bits.
`timescale 1ns/10ps
`default_nettype none

module smcs_uart_rx
	import smcs_pkg::*;
(
	// Clock, reset and enable
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	// Line, already synchronised
	input wire logic rx_i,
	// Character format
	input wire logic [15:0] bit_div_i,
	input wire logic [1:0] parity_i,
	input wire logic stop2_i,
	// Received character
	output logic busy_o,
	output logic byte_valid_o,
	output logic [7:0] byte_o,
	output logic byte_err_o
);

	// ==========================================================================
	// State
	// ==========================================================================
	typedef enum logic [2:0] {
		RX_IDLE = 3'h0,
		RX_START = 3'h1,
		RX_DATA = 3'h3,
		RX_PARITY = 3'h2,
		RX_STOP = 3'h6
	} smcs_rx_state_type;

	typedef struct packed {
		smcs_rx_state_type fsm;
		logic [15:0] cnt;
		logic [2:0] bitn;
		logic [7:0] shift;
		logic perr;
		logic ferr;
		logic stop_more;
		logic valid;
		logic [7:0] data;
		logic err;
	} smcs_rx_type;

	smcs_rx_type st;
	smcs_rx_type next_st;

	always_comb
	begin
		next_st = st;
		next_st.valid = 1'b0;
		unique case (st.fsm)
			RX_IDLE:
				if (!rx_i)
				begin
					// Sample in the middle of each bit to ride out edge skew.
					next_st.fsm = RX_START;
					next_st.cnt = bit_div_i >> 1;
					next_st.perr = 1'b0;
					next_st.ferr = 1'b0;
				end
			RX_START:
				if (st.cnt != 16'h0000)
					next_st.cnt = st.cnt - 16'h0001;
				else if (rx_i)
					next_st.fsm = RX_IDLE;
				else
				begin
					next_st.fsm = RX_DATA;
					next_st.cnt = bit_div_i - 16'h0001;
					next_st.bitn = 3'h0;
				end
			RX_DATA:
				if (st.cnt != 16'h0000)
					next_st.cnt = st.cnt - 16'h0001;
				else
				begin
					next_st.shift = {rx_i, st.shift[7:1]};
					next_st.cnt = bit_div_i - 16'h0001;
					next_st.bitn = st.bitn + 3'h1;
					if (st.bitn == 3'h7)
					begin
						next_st.fsm = (parity_i == PARITY_NONE) ? RX_STOP : RX_PARITY;
						next_st.stop_more = stop2_i;
					end
				end
			RX_PARITY:
				if (st.cnt != 16'h0000)
					next_st.cnt = st.cnt - 16'h0001;
				else
				begin
					next_st.perr = rx_i ^ (^st.shift) ^ (parity_i == PARITY_ODD);
					next_st.fsm = RX_STOP;
					next_st.cnt = bit_div_i - 16'h0001;
				end
			RX_STOP:
				if (st.cnt != 16'h0000)
					next_st.cnt = st.cnt - 16'h0001;
				else if (st.stop_more)
				begin
					next_st.ferr = st.ferr | !rx_i;
					next_st.stop_more = 1'b0;
					next_st.cnt = bit_div_i - 16'h0001;
				end
				else
				begin
					next_st.fsm = RX_IDLE;
					next_st.valid = 1'b1;
					next_st.data = st.shift;
					next_st.err = st.perr | st.ferr | !rx_i;
				end
			default:
				next_st.fsm = RX_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			st <= '0;
		else if (ce_i)
			st <= next_st;
	end

	assign busy_o = (st.fsm != RX_IDLE);
	assign byte_valid_o = st.valid & ce_i;
	assign byte_o = st.data;
	assign byte_err_o = st.err;

endmodule : smcs_uart_rx

`default_nettype wire

// file: rtl/smcs_command_slave.sv
// Serial write-single-register command slave holding operation entry 0 and the start request.
`timescale 1ns/10ps
`default_nettype none

module smcs_command_slave
	import smcs_pkg::*;
#(
	parameter int unsigned CLK_FREQ_HZ = CLK_HZ,
	parameter int unsigned SILENT_CYCLES = SILENT_CYC
)
(
	// Clock, reset and enable
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	// Line and switch pins
	input wire logic rx_i,
	input wire logic [7:0] dev_addr_i,
	input wire logic [3:0] baud_sel_i,
	input wire logic [1:0] parity_sel_i,
	input wire logic stop2_i,
	// Operation data and command
	output smcs_regs_type regs_o,
	output logic start_req_o,
	output logic start_entry0_o,
	// Communication status
	output logic comm_err_o,
	output logic comm_err_flag_o
);

	// ==========================================================================
	// Parameter check
	// ==========================================================================
	if (SILENT_CYCLES < 1 || SILENT_CYCLES > 24'hffffff)
	begin : g_bad_silent
		$error("SILENT_CYCLES must lie in 1 to 16777215");
	end

	// The divisors follow the clock parameter, so the receiver serves any system clock in the divider's range.
	localparam int unsigned MIN_BIT_CYC = 8;
	localparam logic [15:0] DIV_R9600 = 16'(CLK_FREQ_HZ / RATE_9600);
	localparam logic [15:0] DIV_R19200 = 16'(CLK_FREQ_HZ / RATE_19200);
	localparam logic [15:0] DIV_R38400 = 16'(CLK_FREQ_HZ / RATE_38400);
	localparam logic [15:0] DIV_R57600 = 16'(CLK_FREQ_HZ / RATE_57600);
	localparam logic [15:0] DIV_R115200 = 16'(CLK_FREQ_HZ / RATE_115200);

	if (CLK_FREQ_HZ / RATE_115200 < MIN_BIT_CYC || CLK_FREQ_HZ / RATE_9600 > 32'h0000ffff)
	begin : g_bad_clock
		$error("CLK_FREQ_HZ gives a bit time outside the divider range");
	end

	// ==========================================================================
	// State
	// ==========================================================================
	typedef struct packed {
		smcs_pins_type s1;
		smcs_pins_type s2;
		logic [23:0] silent;
		logic [3:0] nbytes;
		logic [7:0][7:0] frame;
		logic [15:0] crc;
		logic berr;
		smcs_regs_type regs;
		logic err_flag;
		logic err_pulse;
	} smcs_slave_type;

	smcs_slave_type st;
	smcs_slave_type next_st;
	smcs_pins_type pins;
	logic [15:0] bit_div;
	logic rx_busy;
	logic rx_valid;
	logic [7:0] rx_byte;
	logic rx_err;
	logic frame_end;
	logic check_ok;
	logic addr_hit;
	logic wr_en;
	logic [15:0] wr_addr;
	logic [15:0] wr_val;

	assign pins = '{rx: rx_i, stop2: stop2_i, parity: parity_sel_i, baud: baud_sel_i, addr: dev_addr_i};

	always_comb
	begin
		unique case (st.s2.baud)
			BAUD_SEL_19200: bit_div = DIV_R19200;
			BAUD_SEL_38400: bit_div = DIV_R38400;
			BAUD_SEL_57600: bit_div = DIV_R57600;
			BAUD_SEL_115200: bit_div = DIV_R115200;
			default: bit_div = DIV_R9600;
		endcase
	end

	smcs_uart_rx u_rx (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.ce_i(ce_i),
		.rx_i(st.s2.rx),
		.bit_div_i(bit_div),
		.parity_i(st.s2.parity),
		.stop2_i(st.s2.stop2),
		.busy_o(rx_busy),
		.byte_valid_o(rx_valid),
		.byte_o(rx_byte),
		.byte_err_o(rx_err)
	);

	// ==========================================================================
	// Frame decode
	// ==========================================================================
	// A frame ends when the line has been quiet for the silent interval.
	assign frame_end = ce_i && !rx_valid && !rx_busy && st.nbytes != 4'h0
		&& st.silent == 24'(SILENT_CYCLES - 1);
	// The check bytes arrive low first, so running the CRC over them leaves zero.
	assign check_ok = st.crc == CRC_RESIDUE && !st.berr;
	assign addr_hit = st.frame[POS_SLAVE] == BCAST_ADDR
		|| (st.frame[POS_SLAVE] == st.s2.addr && st.s2.addr != BCAST_ADDR);
	assign wr_addr = {st.frame[POS_REG_HI], st.frame[POS_REG_LO]};
	assign wr_val = {st.frame[POS_VAL_HI], st.frame[POS_VAL_LO]};
	assign wr_en = frame_end && check_ok && addr_hit && st.nbytes == FRAME_LEN
		&& st.frame[POS_FUNC] == FUNC_WRITE_ONE;

	always_comb
	begin
		next_st = st;
		next_st.s1 = pins;
		next_st.s2 = st.s1;
		next_st.err_pulse = 1'b0;
		if (rx_valid)
		begin
			// Longer frames are still checked so a corrupted one is reported.
			if (st.nbytes < FRAME_LEN)
				next_st.frame[st.nbytes[2:0]] = rx_byte;
			next_st.nbytes = (st.nbytes < FRAME_LEN) ? st.nbytes + 4'h1 : FRAME_OVER;
			next_st.crc = smcs_crc_step(st.crc, rx_byte);
			next_st.berr = st.berr | rx_err;
			next_st.silent = '0;
		end
		else if (rx_busy || st.nbytes == 4'h0)
			next_st.silent = '0;
		else if (frame_end)
		begin
			next_st.nbytes = 4'h0;
			next_st.crc = CRC_INIT;
			next_st.berr = 1'b0;
			next_st.silent = '0;
			if (!check_ok)
			begin
				next_st.err_flag = 1'b1;
				next_st.err_pulse = 1'b1;
			end
			else if (addr_hit)
				next_st.err_flag = 1'b0;
			if (wr_en)
			begin
				unique case (wr_addr)
					REG_MODE: next_st.regs.entry0_move_mode = wr_val;
					REG_POS: next_st.regs.entry0_target_position = wr_val;
					REG_SPEED: next_st.regs.entry0_run_speed = wr_val;
					REG_ACCEL: next_st.regs.entry0_accel_rate = wr_val;
					REG_DECEL: next_st.regs.entry0_decel_rate = wr_val;
					REG_CMD: next_st.regs.drive_input_command = wr_val;
					default: next_st.regs = st.regs;
				endcase
			end
		end
		else
			next_st.silent = st.silent + 24'h000001;
	end

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			st <= '0;
			st.crc <= CRC_INIT;
			st.s1.rx <= 1'b1;
			st.s2.rx <= 1'b1;
			st.regs <= '{default: REG_RESET};
		end
		else if (ce_i)
			st <= next_st;
	end

	// ==========================================================================
	// Outputs
	// ==========================================================================
	assign regs_o = st.regs;
	assign start_req_o = st.regs.drive_input_command[CMD_START_BIT];
	// Entry 0 is launched only when no data-selection bit picks another entry.
	assign start_entry0_o = start_req_o
		&& st.regs.drive_input_command[CMD_SEL_MSB:0] == '0;
	assign comm_err_o = st.err_pulse;
	assign comm_err_flag_o = st.err_flag;

	// ==========================================================================
	// Assertions
	// ==========================================================================
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);

	mode_write_a: assert property (wr_en && wr_addr == REG_MODE |=> regs_o.entry0_move_mode == $past(wr_val))
		else $error("mode register missed a write");
	pos_write_a: assert property (wr_en && wr_addr == REG_POS |=> regs_o.entry0_target_position == $past(wr_val))
		else $error("position register missed a write");
	speed_write_a: assert property (wr_en && wr_addr == REG_SPEED |=> regs_o.entry0_run_speed == $past(wr_val))
		else $error("speed register missed a write");
	accel_write_a: assert property (wr_en && wr_addr == REG_ACCEL |=> regs_o.entry0_accel_rate == $past(wr_val))
		else $error("acceleration register missed a write");
	decel_write_a: assert property (wr_en && wr_addr == REG_DECEL |=> regs_o.entry0_decel_rate == $past(wr_val))
		else $error("deceleration register missed a write");
	start_raise_a: assert property (wr_en && wr_addr == REG_CMD && wr_val == CMD_START
		|=> start_req_o && start_entry0_o)
		else $error("start command did not raise the start request");
	start_entry_a: assert property (wr_en && wr_addr == REG_CMD && wr_val[CMD_SEL_MSB:0] != '0 |=> !start_entry0_o)
		else $error("entry 0 start with another selection active");
	bad_check_a: assert property (frame_end && !check_ok |=> comm_err_o && comm_err_flag_o && $stable(regs_o))
		else $error("bad check not discarded or not flagged");
	foreign_addr_a: assert property (frame_end && !addr_hit |=> $stable(regs_o))
		else $error("frame for another slave changed a register");
	bcast_take_a: assert property (frame_end && check_ok && st.frame[POS_SLAVE] == BCAST_ADDR
		&& st.nbytes == FRAME_LEN && st.frame[POS_FUNC] == FUNC_WRITE_ONE && wr_addr == REG_POS
		|=> regs_o.entry0_target_position == $past(wr_val))
		else $error("broadcast write not accepted");
	quiet_end_a: assert property (frame_end |-> $past(!rx_busy, 1) && !rx_valid)
		else $error("frame closed while the line was active");

	good_write_c: cover property (wr_en && wr_addr == REG_POS);
	start_c: cover property (wr_en && wr_addr == REG_CMD ##1 start_entry0_o);
	bad_crc_c: cover property (frame_end && !check_ok);
	bcast_c: cover property (wr_en && st.frame[POS_SLAVE] == BCAST_ADDR);

endmodule : smcs_command_slave

`default_nettype wire

// file: tb/smcs_host_model.sv
// Host controller model that sends write-single-register queries on the serial line.
`timescale 1ns/10ps
`default_nettype none

module smcs_host_model
	import smcs_pkg::*;
#(
	parameter int unsigned GAP_CYC = 6170
)
(
	// Clock and bit time in clock cycles
	input wire logic mclk_i,
	input wire logic [15:0] bit_cyc_i,
	// Character format, shared with the slave's switches
	input wire logic [1:0] parity_i,
	input wire logic stop2_i,
	// Line towards the slave, idle high
	output logic tx_o
);
	// ==========================================================================
	// Character and frame senders
	// ==========================================================================
	// The bus is biased to the idle level between frames, so the line rests high.
	initial tx_o = 1'b1;

	task automatic bit_out(input logic v);
		tx_o <= v;
		repeat (bit_cyc_i) @(posedge mclk_i);
	endtask : bit_out

	task automatic send_char(input logic [7:0] b);
		bit_out(1'b0);
		for (int i = 0; i < 8; i++)
			bit_out(b[i]);
		if (parity_i != PARITY_NONE)
			bit_out((^b) ^ (parity_i == PARITY_ODD));
		bit_out(1'b1);
		if (stop2_i)
			bit_out(1'b1);
	endtask : send_char

	// A corrupted query flips every check bit, so the slave must see a bad sum.
	task automatic send_query(input logic [7:0] addr, input logic [7:0] func, input logic [15:0] ra,
		input logic [15:0] val, input logic corrupt);
		logic [7:0] q[6];
		logic [15:0] c;
		q = '{addr, func, ra[15:8], ra[7:0], val[15:8], val[7:0]};
		c = 16'hffff;
		for (int k = 0; k < 6; k++)
		begin
			c = c ^ {8'h00, q[k]};
			for (int j = 0; j < 8; j++)
				c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
		end
		if (corrupt)
			c = ~c;
		for (int k = 0; k < 6; k++)
			send_char(q[k]);
		send_char(c[7:0]);
		send_char(c[15:8]);
		repeat (GAP_CYC) @(posedge mclk_i);
	endtask : send_query

endmodule : smcs_host_model

`default_nettype wire

// file: tb/test_serial_motor_command_slave.sv
// Self-checking testbench of the serial motor command slave.
`timescale 1ns/10ps
`default_nettype none

module test_serial_motor_command_slave
	import smcs_pkg::*;
;
	// ==========================================================================
	// Signals and instances
	// ==========================================================================
	// The slave is built for a slow clock, so every bit time is a whole number of cycles and a frame stays short.
	localparam int unsigned FREQ = RATE_115200 * 16;
	// The silent interval still exceeds the idle gap inside a frame at every rate used.
	localparam int unsigned SIL = 300;
	logic mclk;
	logic resetn;
	logic ce;
	logic [15:0] bit_cyc;
	logic line;
	logic [7:0] dev_addr;
	logic [3:0] baud_sel;
	logic [1:0] parity_sel;
	logic stop2;
	smcs_regs_type regs;
	logic start_req;
	logic start_entry0;
	logic comm_err;
	logic comm_err_flag;
	int n_mismatch = 0;
	int cmp_count = 0;
	int n_errp = 0;
	int e0;

	smcs_command_slave #(.CLK_FREQ_HZ(FREQ), .SILENT_CYCLES(SIL)) dut_u (.mclk_i(mclk), .resetn_i(resetn), .ce_i(ce),
		.rx_i(line), .dev_addr_i(dev_addr), .baud_sel_i(baud_sel), .parity_sel_i(parity_sel),
		.stop2_i(stop2), .regs_o(regs), .start_req_o(start_req), .start_entry0_o(start_entry0),
		.comm_err_o(comm_err), .comm_err_flag_o(comm_err_flag));

	smcs_host_model #(.GAP_CYC(SIL + 32)) host_u (.mclk_i(mclk), .bit_cyc_i(bit_cyc),
		.parity_i(parity_sel), .stop2_i(stop2), .tx_o(line));

	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	always @(posedge mclk)
		if (comm_err === 1'b1)
			n_errp <= n_errp + 1;

	// ==========================================================================
	// Shared tasks
	// ==========================================================================
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic conclude;
		if (n_mismatch == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude

	function automatic logic [15:0] rate_cyc(input logic [3:0] sel);
		unique case (sel)
			BAUD_SEL_19200: return 16'(FREQ / RATE_19200);
			BAUD_SEL_38400: return 16'(FREQ / RATE_38400);
			BAUD_SEL_57600: return 16'(FREQ / RATE_57600);
			BAUD_SEL_115200: return 16'(FREQ / RATE_115200);
			default: return 16'(FREQ / RATE_9600);
		endcase
	endfunction : rate_cyc

	task automatic wr(input logic [7:0] a, input logic [15:0] ra, input logic [15:0] v);
		host_u.send_query(a, FUNC_WRITE_ONE, ra, v, 1'b0);
	endtask : wr

	// ==========================================================================
	// Scenarios
	// ==========================================================================
	task automatic t_reset;
		check(regs[95:80], 16'h0000);
		check(regs[79:64], 16'h0000);
		check(regs[63:48], 16'h0000);
		check(regs[47:32], 16'h0000);
		check(regs[31:16], 16'h0000);
		check(regs[15:0], 16'h0000);
		check({13'h0, start_req, start_entry0, comm_err_flag}, 16'h0000);
	endtask : t_reset

	// One write at each of the slower rates, then back to the top rate.
	task automatic t_rates;
		for (int b = 0; b < 4; b++)
		begin
			baud_sel <= 4'(b);
			bit_cyc <= rate_cyc(4'(b));
			@(posedge mclk);
			wr(8'h01, REG_DECEL, 16'h0100 + 16'(b));
			check(regs.entry0_decel_rate, 16'h0100 + 16'(b));
		end
		baud_sel <= BAUD_SEL_115200;
		bit_cyc <= rate_cyc(BAUD_SEL_115200);
		@(posedge mclk);
	endtask : t_rates

	// A frame sent while the clock enable is low must leave the target position as it was and the error flag clear.
	task automatic t_freeze;
		ce <= 1'b0;
		@(posedge mclk);
		wr(8'h01, REG_POS, 16'h4444);
		ce <= 1'b1;
		@(posedge mclk);
		check(regs.entry0_target_position, 16'h3333);
		check({15'h0000, comm_err_flag}, 16'h0000);
	endtask : t_freeze

	// Odd parity with two stop bits, then no parity with one stop bit, then back to the even single-stop default.
	task automatic t_format;
		parity_sel <= PARITY_ODD;
		stop2 <= 1'b1;
		@(posedge mclk);
		wr(8'h01, REG_MODE, 16'h0003);
		check(regs.entry0_move_mode, 16'h0003);
		check({15'h0000, comm_err_flag}, 16'h0000);
		parity_sel <= PARITY_NONE;
		stop2 <= 1'b0;
		@(posedge mclk);
		wr(8'h01, REG_ACCEL, 16'h0007);
		check(regs.entry0_accel_rate, 16'h0007);
		parity_sel <= PARITY_EVEN;
		@(posedge mclk);
	endtask : t_format

	task automatic t_entry;
		wr(8'h01, REG_MODE, MODE_INCREMENTAL);
		check(regs.entry0_move_mode, 16'h0000);
		wr(8'h01, REG_POS, 16'h2134);
		check(regs.entry0_target_position, 16'h2134);
		wr(8'h01, {8'h04, 8'h81}, 16'h07d0);
		check(regs.entry0_run_speed, 16'h07d0);
		wr(8'h01, REG_ACCEL, 16'h05dc);
		check(regs.entry0_accel_rate, 16'h05dc);
		wr(8'h01, REG_DECEL, 16'h0bb8);
		check(regs.entry0_decel_rate, 16'h0bb8);
		check(regs.entry0_accel_rate, 16'h05dc);
	endtask : t_entry

	task automatic t_start;
		wr(8'h01, REG_CMD, CMD_START);
		check(regs.drive_input_command, 16'h0008);
		check({14'h0, start_req, start_entry0}, 16'h0003);
		wr(8'h01, REG_CMD, 16'h000a);
		check({14'h0, start_req, start_entry0}, 16'h0002);
		wr(8'h01, REG_CMD, 16'h0000);
		check({14'h0, start_req, start_entry0}, 16'h0000);
	endtask : t_start

	task automatic t_reject;
		e0 = n_errp;
		host_u.send_query(8'h01, FUNC_WRITE_ONE, REG_POS, 16'h1111, 1'b1);
		check(regs.entry0_target_position, 16'h2134);
		check(16'(n_errp - e0), 16'h0001);
		check({15'h0000, comm_err_flag}, 16'h0001);
		wr(8'h02, REG_POS, 16'h2222);
		check(regs.entry0_target_position, 16'h2134);
		check({15'h0000, comm_err_flag}, 16'h0001);
		host_u.send_query(8'h01, 8'h03, REG_POS, 16'h0001, 1'b0);
		check(regs.entry0_target_position, 16'h2134);
		wr(8'h00, REG_POS, 16'h3333);
		check(regs.entry0_target_position, 16'h3333);
		check({15'h0000, comm_err_flag}, 16'h0000);
		check(16'(n_errp - e0), 16'h0001);
	endtask : t_reject

	// ==========================================================================
	// Main sequence and watchdog
	// ==========================================================================
	initial
	begin
		resetn <= 1'b0;
		ce <= 1'b1;
		bit_cyc <= rate_cyc(BAUD_SEL_115200);
		dev_addr <= 8'h01;
		baud_sel <= BAUD_SEL_115200;
		parity_sel <= PARITY_EVEN;
		stop2 <= 1'b0;
		repeat (6) @(posedge mclk);
		resetn <= 1'b1;
		repeat (4) @(posedge mclk);
		t_reset();
		t_format();
		t_rates();
		t_entry();
		t_start();
		t_reject();
		t_freeze();
		conclude();
	end

	initial
	begin
		repeat (100_000) @(posedge mclk);
		n_mismatch++;
		conclude();
	end

endmodule : test_serial_motor_command_slave

`default_nettype wire
